// >>> pmwc_pkg.sv
// package: constants and types for the power-state and wake control block
package pmwc_pkg;

    // register indices (byte address = 4 * index)
    localparam logic [7:0] PMWC_REG_CTRL = 8'h00;
    localparam logic [7:0] PMWC_REG_PMCSR = 8'h01;
    localparam logic [7:0] PMWC_REG_CFG = 8'h02;
    localparam logic [7:0] PMWC_REG_STATUS = 8'h03;
    localparam logic [7:0] PMWC_REG_PMCAP = 8'h04;
    localparam logic [7:0] PMWC_REG_CFG_OFS_PMCAP = 8'hDE;

    // control register fields
    localparam int PMWC_CTRL_BAR_WR_BIT = 0;
    // pmcsr fields
    localparam int PMWC_PMCSR_STATE_LSB = 0;
    localparam int PMWC_PMCSR_PME_EN_BIT = 8;
    localparam int PMWC_PMCSR_PME_STS_BIT = 15;
    // config register fields
    localparam int PMWC_CFG_MAC_PME_EN_BIT = 0;
    localparam int PMWC_CFG_STANDBY_EN_BIT = 1;
    localparam int PMWC_CFG_LOWPWR_EN_BIT = 2;
    localparam int PMWC_CFG_DEEP_DIS_BIT = 6;

    localparam logic [7:0] PMWC_CFG_RESET = 8'h04;
    localparam logic [15:0] PMWC_PMCAP_BASE = 16'h0022;
    localparam logic [15:0] PMWC_PMCAP_AUX = 16'hFE22;

    // idle cycles before dynamic standby
    localparam int PMWC_IDLE_NS = 1000;
    localparam int PMWC_CLK_NS = 40;
    localparam int PMWC_IDLE_CYC = (PMWC_IDLE_NS + PMWC_CLK_NS - 1) / PMWC_CLK_NS;

    typedef enum logic [2:0] {
        PMWC_D0U = 3'b000,
        PMWC_D0A = 3'b001,
        PMWC_D1 = 3'b011,
        PMWC_D2 = 3'b010,
        PMWC_D3 = 3'b110
    } pmwc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pmwc_req_t;

    typedef struct packed {
        logic link_valid;
        logic pkt_match;
        logic bus_idle;
    } pmwc_link_t;

endpackage

// >>> pmwc_edge.sv
// rising and falling edge detector with registered outputs
module pmwc_edge
    import pmwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sig_i,
    output logic rise_o,
    output logic fall_o,
    output logic level_o
);
    logic prev_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // track the pin in reset so an idle-high input gives no false edge
            prev_r <= sig_i;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            prev_r <= sig_i;
            rise_o <= sig_i & ~prev_r;
            fall_o <= ~sig_i & prev_r;
        end
    end

    assign level_o = prev_r;
endmodule

// >>> pmwc_top.sv
// power-state tracking, wake event and internal initialization control
//
// Overview of operation
// - outside D0 only configuration accesses are accepted on the bus
// - power-on reset enters uninitialized D0; a base address write makes it active
// - active D0 enters and leaves standby on its own, visible to software in the status register
// - in D1 no bus cycles or interrupts are started
// - in D1 wake events raise the power event output
// - D2 with link down may use low power, watching only for link up
// - a driver-register bit allows or blocks the invalid-link low power state
// - D3 acts like D2; with events disabled no wake and no link upkeep
// - aux supply sense sampled during power-on reset sets capability value
// - alternate reset low initializes like power-on reset
// - isolate ignores bus inputs other than bus idle and floats outputs except power event
// - with events enabled bus reset keeps power registers untouched
// - init pulse on reset in D0-D2, reset release in D3, isolate release
// - init pulse clears configuration, MAC setup and memory state
// - active D0 flags a wake on link loss and on link gain
// - low power states with link wake on packets or link loss
// - wake events only signalled while event enable is set
// - packet match input counts only in powered-down states
// - every link status change is a wake event in all states
// - power event needs both event enable and MAC enable
// - standby enable at zero keeps the block always active
// - deep power-down setting 0 allows it in D3 without events
module pmwc_top
    import pmwc_pkg::*;
#(
    parameter int IDLE_CYC = PMWC_IDLE_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic ALTERNATE_POR_N_I,
    input wire logic BUS_RST_N_I,
    input wire logic ISOLATE_N_I,
    input wire logic AUX_SUPPLY_SENSE_I,
    input wire logic LINK_VALID_I,
    input wire logic PKT_MATCH_I,
    input wire logic BUS_IDLE_I,
    input wire logic BUS_CFG_ACC_I,
    input wire logic BUS_MEM_ACC_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    output logic PME_N_O,
    output logic BUS_OE_O,
    output logic ACCEPT_CFG_O,
    output logic ACCEPT_MEM_O,
    output logic MASTER_EN_O,
    output logic IRQ_EN_O,
    output logic STANDBY_O,
    output logic LOW_POWER_O,
    output logic DEEP_PWR_DOWN_O,
    output logic LINK_KEEP_O,
    output logic INIT_O
);
    ////////////////////////////////////////////////////////////////////////
    pmwc_req_t req;
    pmwc_link_t lnk;
    pmwc_state_t state_r;
    pmwc_state_t state_nxt;
    logic por_n;
    logic iso;
    logic bus_rst;
    logic rst_fall;
    logic rst_rise;
    logic iso_rise;
    logic link_rise;
    logic link_fall;
    logic link_lvl;
    logic iso_prev_r;
    logic pme_en_r;
    logic pme_sts_r;
    logic [7:0] cfg_r;
    logic aux_r;
    logic init_nxt;
    logic wake_evt;
    logic [$clog2(IDLE_CYC+1)-1:0] idle_cnt_r;
    logic [1:0] dstate_req;

    // alternate reset acts as a second power-on reset
    assign por_n = RST_N_I & ALTERNATE_POR_N_I;
    // isolate masks every bus input but bus idle, bus reset included
    assign iso = ~ISOLATE_N_I;
    assign bus_rst = ~BUS_RST_N_I & ~iso;
    assign req = '{addr: REG_ADDR_I, wdata: REG_WDATA_I,
                   wr: REG_WR_I & ~iso, rd: REG_RD_I & ~iso};
    assign lnk = '{link_valid: LINK_VALID_I, pkt_match: PKT_MATCH_I, bus_idle: BUS_IDLE_I};
    assign dstate_req = req.wdata[PMWC_PMCSR_STATE_LSB +: 2];

    function automatic logic is_d0(input pmwc_state_t s);
        return (s == PMWC_D0U) || (s == PMWC_D0A);
    endfunction

    pmwc_edge u_rst_edge (
        .clk_i(SYS_CLK_I),
        .rst_n_i(por_n),
        .sig_i(bus_rst),
        .rise_o(),
        .fall_o(rst_fall),
        .level_o()
    );

    pmwc_edge u_link_edge (
        .clk_i(SYS_CLK_I),
        .rst_n_i(por_n),
        .sig_i(lnk.link_valid),
        .rise_o(link_rise),
        .fall_o(link_fall),
        .level_o(link_lvl)
    );

    assign rst_rise = rst_fall;
    assign iso_rise = iso_prev_r & ~iso;
    // bus reset release shows as the falling edge of the internal active-high reset

    ////////////////////////////////////////////////////////////////////////
    // aux sense is caught only while power-on reset holds
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            aux_r <= AUX_SUPPLY_SENSE_I;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            iso_prev_r <= 1'b0;
        end else begin
            iso_prev_r <= iso;
        end
    end

    // init pulse triggers
    always_comb begin
        init_nxt = (bus_rst && !(state_r == PMWC_D3))
                   || (rst_rise && state_r == PMWC_D3)
                   || iso_rise;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            INIT_O <= 1'b1;
        end else begin
            INIT_O <= init_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PMWC_D0U: begin
                if (req.wr && req.addr == PMWC_REG_CTRL && req.wdata[PMWC_CTRL_BAR_WR_BIT]) begin
                    state_nxt = PMWC_D0A;
                end
            end
            PMWC_D0A, PMWC_D1, PMWC_D2, PMWC_D3: begin
                if (req.wr && req.addr == PMWC_REG_PMCSR) begin
                    case (dstate_req)
                        2'd0: state_nxt = PMWC_D0A;
                        2'd1: state_nxt = PMWC_D1;
                        2'd2: state_nxt = PMWC_D2;
                        default: state_nxt = PMWC_D3;
                    endcase
                end
            end
            default: state_nxt = PMWC_D0U;
        endcase
    end

    // init pulse returns to uninitialized D0 and clears configuration
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            state_r <= PMWC_D0U;
        end else if (INIT_O) begin
            state_r <= PMWC_D0U;
        end else begin
            state_r <= state_nxt;
        end
    end

    // MAC configuration, reset by init pulse
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            cfg_r <= PMWC_CFG_RESET;
        end else if (INIT_O) begin
            cfg_r <= PMWC_CFG_RESET;
        end else if (req.wr && req.addr == PMWC_REG_CFG) begin
            cfg_r <= req.wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake events: link changes in every state, packets only when powered down
    assign wake_evt = link_rise || link_fall
                      || (lnk.pkt_match && link_lvl && !is_d0(state_r));

    // power registers survive bus reset while events are enabled
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            pme_en_r <= 1'b0;
        end else if (INIT_O && !pme_en_r) begin
            pme_en_r <= 1'b0;
        end else if (req.wr && req.addr == PMWC_REG_PMCSR) begin
            pme_en_r <= req.wdata[PMWC_PMCSR_PME_EN_BIT];
        end
    end

    // status: set wins over write-one-to-clear
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            pme_sts_r <= 1'b0;
        end else if (wake_evt && pme_en_r && cfg_r[PMWC_CFG_MAC_PME_EN_BIT]) begin
            pme_sts_r <= 1'b1;
        end else if (req.wr && req.addr == PMWC_REG_PMCSR
                     && req.wdata[PMWC_PMCSR_PME_STS_BIT]) begin
            pme_sts_r <= 1'b0;
        end else if (INIT_O && !pme_en_r) begin
            pme_sts_r <= 1'b0;
        end
    end

    // power event stays driven under isolate
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            PME_N_O <= 1'b1;
        end else begin
            PME_N_O <= ~(pme_sts_r & pme_en_r & cfg_r[PMWC_CFG_MAC_PME_EN_BIT]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus gating per state
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            BUS_OE_O <= 1'b0;
            ACCEPT_CFG_O <= 1'b0;
            ACCEPT_MEM_O <= 1'b0;
            MASTER_EN_O <= 1'b0;
            IRQ_EN_O <= 1'b0;
        end else begin
            BUS_OE_O <= ~iso;
            ACCEPT_CFG_O <= ~iso & BUS_CFG_ACC_I;
            ACCEPT_MEM_O <= ~iso & BUS_MEM_ACC_I & is_d0(state_r);
            MASTER_EN_O <= ~iso & (state_r == PMWC_D0A);
            IRQ_EN_O <= ~iso & (state_r == PMWC_D0A);
        end
    end

    // dynamic standby: autonomous, needs the stored enable
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            idle_cnt_r <= '0;
            STANDBY_O <= 1'b0;
        end else if (state_r != PMWC_D0A || !cfg_r[PMWC_CFG_STANDBY_EN_BIT] || !lnk.bus_idle) begin
            idle_cnt_r <= '0;
            STANDBY_O <= 1'b0;
        end else if (idle_cnt_r == ($clog2(IDLE_CYC+1))'(IDLE_CYC)) begin
            STANDBY_O <= 1'b1;
        end else begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end

    // low-power and deep power-down modes
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            LOW_POWER_O <= 1'b0;
            DEEP_PWR_DOWN_O <= 1'b0;
            LINK_KEEP_O <= 1'b1;
        end else begin
            LOW_POWER_O <= (state_r == PMWC_D2 || state_r == PMWC_D3) && !lnk.link_valid
                           && cfg_r[PMWC_CFG_LOWPWR_EN_BIT];
            DEEP_PWR_DOWN_O <= (state_r == PMWC_D3) && !pme_en_r
                               && !cfg_r[PMWC_CFG_DEEP_DIS_BIT];
            LINK_KEEP_O <= is_d0(state_r) || (pme_en_r
                           && !((state_r == PMWC_D2 || state_r == PMWC_D3)
                                && !lnk.link_valid && cfg_r[PMWC_CFG_LOWPWR_EN_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, one cycle later; unmapped reads zero
    always_ff @(posedge SYS_CLK_I) begin
        if (!por_n) begin
            REG_RDATA_O <= '0;
        end else if (req.rd) begin
            case (req.addr)
                PMWC_REG_CTRL: REG_RDATA_O <= {29'h0, state_r};
                PMWC_REG_PMCSR: REG_RDATA_O <= {16'h0, pme_sts_r, 6'h0, pme_en_r,
                    6'h0, (state_r == PMWC_D2 || state_r == PMWC_D3),
                    (state_r == PMWC_D1 || state_r == PMWC_D3)};
                PMWC_REG_CFG: REG_RDATA_O <= {24'h0, cfg_r};
                PMWC_REG_STATUS: REG_RDATA_O <= {28'h0, LOW_POWER_O, STANDBY_O,
                    link_lvl, aux_r};
                PMWC_REG_PMCAP: REG_RDATA_O <= {16'h0,
                    aux_r ? PMWC_PMCAP_AUX : PMWC_PMCAP_BASE};
                default: REG_RDATA_O <= '0;
            endcase
        end else begin
            REG_RDATA_O <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence pme_set_s;
        wake_evt && pme_en_r && cfg_r[PMWC_CFG_MAC_PME_EN_BIT];
    endsequence
    sequence pme_out_s;
        ##2 !PME_N_O;
    endsequence

    pme_assert_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        pme_set_s |-> pme_out_s) else $error("power event not raised after wake");
    pme_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        !PME_N_O |-> $past(pme_en_r) && $past(cfg_r[PMWC_CFG_MAC_PME_EN_BIT]))
        else $error("power event without both enables");
    pme_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        pme_sts_r && !(req.wr && req.addr == PMWC_REG_PMCSR) |=> pme_sts_r)
        else $error("event status dropped without clear");
    bar_active_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        state_r == PMWC_D0U && req.wr && req.addr == PMWC_REG_CTRL
        && req.wdata[0] && !INIT_O |=> state_r == PMWC_D0A)
        else $error("base address write did not activate");
    mem_block_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        !is_d0(state_r) |=> !ACCEPT_MEM_O) else $error("memory access outside D0");
    d1_master_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        state_r == PMWC_D1 |=> !MASTER_EN_O && !IRQ_EN_O)
        else $error("bus master active in D1");
    iso_float_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        iso |=> !BUS_OE_O) else $error("bus driven while isolated");
    init_trig_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        iso_rise |=> INIT_O) else $error("no init on isolate release");
    standby_off_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        !cfg_r[PMWC_CFG_STANDBY_EN_BIT] |=> !STANDBY_O) else $error("standby while disabled");
    deep_pd_a: assert property (@(posedge SYS_CLK_I) disable iff (!por_n)
        DEEP_PWR_DOWN_O |-> $past(state_r == PMWC_D3) && !$past(pme_en_r))
        else $error("deep power-down outside D3 or with events on");
endmodule

// >>> pmwc_host_model.sv
// host side model: bus reset, bus power state and access requests
module pmwc_host_model (
    input wire logic clk_i,
    output logic bus_rst_n_o,
    output logic isolate_n_o,
    output logic cfg_acc_o,
    output logic mem_acc_o,
    output logic bus_idle_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic b3_r = 1'b0;
    logic warm_r = 1'b0;
    // isolate follows bus reset while bus power is off, released on return to B0
    assign isolate_n_o = ~b3_r;
    assign bus_rst_n_o = ~(b3_r | warm_r);
    initial begin
        cfg_acc_o = 1'b0;
        mem_acc_o = 1'b0;
        bus_idle_o = 1'b0;
    end
    task automatic set_warm(input logic v);
        @(posedge clk_i);
        warm_r <= v;
    endtask
    task automatic set_b3(input logic v);
        @(posedge clk_i);
        b3_r <= v;
    endtask
    task automatic access(input logic c, input logic m);
        @(posedge clk_i);
        cfg_acc_o <= c;
        mem_acc_o <= m;
    endtask
    task automatic idle(input logic v);
        @(posedge clk_i);
        bus_idle_o <= v;
    endtask
endmodule

// >>> test_pmwc_top.sv
// testbench for the power-state and wake control block
module test_pmwc_top
    import pmwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IDLE = 4;
    logic clk, rst_n, alt_n, aux, link, pkt, wr, rd;
    logic bus_rst_n, iso_n, cfg_acc, mem_acc, idle;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    // 0 pme_n 1 standby 2 low power 3 deep 4 link keep 5 init 6 oe 7 cfg 8 mem 9 master 10 irq
    logic [10:0] obs;
    int err_count = 0;
    int total_checks = 0;

    pmwc_host_model host (.clk_i(clk), .bus_rst_n_o(bus_rst_n), .isolate_n_o(iso_n),
        .cfg_acc_o(cfg_acc), .mem_acc_o(mem_acc), .bus_idle_o(idle));
    pmwc_top #(.IDLE_CYC(IDLE)) uut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
        .ALTERNATE_POR_N_I(alt_n), .BUS_RST_N_I(bus_rst_n), .ISOLATE_N_I(iso_n),
        .AUX_SUPPLY_SENSE_I(aux), .LINK_VALID_I(link), .PKT_MATCH_I(pkt),
        .BUS_IDLE_I(idle), .BUS_CFG_ACC_I(cfg_acc), .BUS_MEM_ACC_I(mem_acc),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdata), .PME_N_O(obs[0]), .BUS_OE_O(obs[6]), .ACCEPT_CFG_O(obs[7]),
        .ACCEPT_MEM_O(obs[8]), .MASTER_EN_O(obs[9]), .IRQ_EN_O(obs[10]),
        .STANDBY_O(obs[1]), .LOW_POWER_O(obs[2]), .DEEP_PWR_DOWN_O(obs[3]),
        .LINK_KEEP_O(obs[4]), .INIT_O(obs[5]));

    ////////////////////////////////////////////////////////////////////////////
    // 25 MHz, comfortably above the minimum the active state needs
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_obs(input int i, input logic v, input int n);
        int k;
        k = 0;
        @(negedge clk);
        while (obs[i] !== v && k < n) begin
            @(negedge clk);
            k++;
        end
        chk({31'h0, obs[i]}, {31'h0, v});
        if (obs[i] !== v) results();
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & m, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic set_link(input logic v);
        @(posedge clk);
        link <= v;
    endtask
    task automatic pulse_pkt();
        @(posedge clk);
        pkt <= 1'b1;
        @(posedge clk);
        pkt <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, pkt, wr, rd} = 4'h0;
        {alt_n, aux, link} = 3'h7;
        addr = 8'h00;
        wdata = 32'h0;
        tick(5);
        rst_n <= 1'b1;
        aux <= 1'b0;
        wait_obs(0, 1'b1, 0);
        rdc(PMWC_REG_PMCAP, 32'hFFFF, 32'h0000FE22);
        rdc(PMWC_REG_CFG, 32'hFF, 32'h04);
        rdc(PMWC_REG_CTRL, 32'h7, 32'h0);
        wait_obs(9, 1'b0, 0);
        $display("test reset done");
        wreg(PMWC_REG_CTRL, 32'h1);
        rdc(PMWC_REG_CTRL, 32'h7, 32'h1);
        host.access(1'b1, 1'b1);
        wait_obs(9, 1'b1, 2);
        wait_obs(10, 1'b1, 2);
        wait_obs(8, 1'b1, 3);
        host.access(1'b0, 1'b1);
        wait_obs(7, 1'b0, 2);
        host.access(1'b1, 1'b1);
        wait_obs(7, 1'b1, 2);
        wreg(PMWC_REG_CFG, 32'h06);
        host.idle(1'b1);
        wait_obs(1, 1'b1, IDLE + 4);
        host.idle(1'b0);
        wait_obs(1, 1'b0, 4);
        wreg(PMWC_REG_CFG, 32'h04);
        host.idle(1'b1);
        tick(IDLE + 8);
        wait_obs(1, 1'b0, 0);
        host.idle(1'b0);
        $display("test active and standby done");
        wreg(PMWC_REG_CFG, 32'h05);
        for (int p = 0; p < 2; p++) begin
            set_link(1'b0);
            tick(3);
            set_link(1'b1);
            tick(6);
            wait_obs(0, 1'b1, 0);
            wreg(PMWC_REG_CFG, 32'h04);
            wreg(PMWC_REG_PMCSR, 32'h8100);
        end
        wreg(PMWC_REG_CFG, 32'h05);
        wreg(PMWC_REG_PMCSR, 32'h8100);
        pulse_pkt();
        tick(8);
        wait_obs(0, 1'b1, 0);
        set_link(1'b0);
        wait_obs(0, 1'b0, 6);
        set_link(1'b1);
        tick(10);
        wait_obs(0, 1'b0, 0);
        wreg(PMWC_REG_PMCSR, 32'h8100);
        wait_obs(0, 1'b1, 4);
        $display("test wake gating done");
        wreg(PMWC_REG_PMCSR, 32'h0101);
        rdc(PMWC_REG_CTRL, 32'h7, 32'h3);
        wait_obs(9, 1'b0, 2);
        wait_obs(10, 1'b0, 0);
        wait_obs(8, 1'b0, 2);
        wait_obs(7, 1'b1, 0);
        wait_obs(4, 1'b1, 0);
        pulse_pkt();
        wait_obs(0, 1'b0, 6);
        wreg(PMWC_REG_PMCSR, 32'h8101);
        wait_obs(0, 1'b1, 4);
        $display("test d1 done");
        wreg(PMWC_REG_PMCSR, 32'h0102);
        set_link(1'b0);
        wait_obs(2, 1'b1, 6);
        wait_obs(4, 1'b0, 4);
        wreg(PMWC_REG_CFG, 32'h01);
        wait_obs(2, 1'b0, 4);
        set_link(1'b1);
        tick(4);
        wreg(PMWC_REG_PMCSR, 32'h8102);
        wait_obs(0, 1'b1, 4);
        host.set_warm(1'b1);
        wait_obs(5, 1'b1, 4);
        host.set_warm(1'b0);
        wait_obs(5, 1'b0, 8);
        rdc(PMWC_REG_CTRL, 32'h7, 32'h0);
        rdc(PMWC_REG_CFG, 32'hFF, 32'h04);
        rdc(PMWC_REG_PMCSR, 32'h100, 32'h100);
        $display("test d2 and bus reset done");
        wreg(PMWC_REG_CTRL, 32'h1);
        wreg(PMWC_REG_PMCSR, 32'h0103);
        rdc(PMWC_REG_CTRL, 32'h7, 32'h6);
        host.set_warm(1'b1);
        tick(4);
        wait_obs(5, 1'b0, 0);
        host.set_warm(1'b0);
        wait_obs(5, 1'b1, 4);
        wait_obs(5, 1'b0, 8);
        wreg(PMWC_REG_CTRL, 32'h1);
        wreg(PMWC_REG_CFG, 32'h05);
        wreg(PMWC_REG_PMCSR, 32'h8103);
        host.set_b3(1'b1);
        wait_obs(6, 1'b0, 3);
        set_link(1'b0);
        wait_obs(0, 1'b0, 6);
        host.set_b3(1'b0);
        wait_obs(5, 1'b1, 4);
        wait_obs(5, 1'b0, 8);
        set_link(1'b1);
        tick(4);
        $display("test d3 and isolate done");
        // isolate release left the block uninitialized; activate before entering D3
        wreg(PMWC_REG_CTRL, 32'h1);
        wreg(PMWC_REG_PMCSR, 32'h8003);
        wait_obs(3, 1'b1, 4);
        wait_obs(4, 1'b0, 4);
        wreg(PMWC_REG_CFG, 32'h44);
        wait_obs(3, 1'b0, 4);
        @(posedge clk);
        alt_n <= 1'b0;
        tick(3);
        alt_n <= 1'b1;
        rdc(PMWC_REG_PMCAP, 32'hFFFF, 32'h00000022);
        rdc(PMWC_REG_CFG, 32'hFF, 32'h04);
        rdc(PMWC_REG_PMCSR, 32'h100, 32'h0);
        rdc(PMWC_REG_CTRL, 32'h7, 32'h0);
        $display("test alternate reset done");
        results();
    end
endmodule
